// ===== smc_pkg.sv
// smc_pkg: constants and types for the sleep mode controller
// assumes: one 200 MHz clock, wake delays given in system clock cycles
package smc_pkg;

  // ----------------------------------------
  // sleep mode select codes
  // ----------------------------------------
  localparam logic [2:0] SMC_MODE_IDLE   = 3'h0;
  localparam logic [2:0] SMC_MODE_NOISE  = 3'h1;
  localparam logic [2:0] SMC_MODE_PDOWN  = 3'h2;
  localparam logic [2:0] SMC_MODE_PSAVE  = 3'h3;
  localparam logic [2:0] SMC_MODE_STBY   = 3'h6;
  localparam logic [2:0] SMC_MODE_XSTBY  = 3'h7;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SMC_HALT_CYCLES  = 4;
  localparam int SMC_STBY_CYCLES  = 6;
  localparam int SMC_CNT_W        = 16;

  // ----------------------------------------
  // wake source vector positions
  // ----------------------------------------
  localparam int SMC_WK_ADC       = 0;
  localparam int SMC_WK_MATCH     = 1;
  localparam int SMC_WK_T2        = 2;
  localparam int SMC_WK_STORE     = 3;
  localparam int SMC_WK_OTHER     = 4;
  localparam int SMC_WK_COMP      = 5;
  localparam int SMC_WK_W         = 6;

  typedef enum logic [2:0] {
    SMC_RUN,
    SMC_SLEEP,
    SMC_SETTLE,
    SMC_HALT
  } smc_state_t;

endpackage : smc_pkg

// ===== smc_wake_if.sv
// smc_wake_if: raw wake events carried into the synchroniser
// assumes: producer is the top module, consumer the synchroniser
`timescale 1ns/1ps
interface smc_wake_if;
  import smc_pkg::*;
  logic [SMC_WK_W-1:0] evt_raw;
  logic [2:0]          ext_raw;
  logic [SMC_WK_W-1:0] evt_sync;
  logic [2:0]          ext_sync;
  modport src (output evt_raw, output ext_raw, input evt_sync, input ext_sync);
  modport dst (input evt_raw, input ext_raw, output evt_sync, output ext_sync);
endinterface : smc_wake_if

// ===== smc_sync.sv
// smc_sync: two-flop synchronisers for wake events
// assumes: inputs may change at any time relative to mclk
`timescale 1ns/1ps
module smc_sync
  import smc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rstn,
  smc_wake_if.dst   wk
);
  localparam int W = SMC_WK_W + 3;

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= {wk.ext_raw, wk.evt_raw};
      sync_q <= meta_q;
    end
  end

  assign wk.evt_sync = sync_q[SMC_WK_W-1:0];
  assign wk.ext_sync = sync_q[W-1:SMC_WK_W];
endmodule : smc_sync

// ===== smc_ctrl.sv
// smc_ctrl: sleep mode controller, clock gating and wake sequencing
// assumes: core pulses sleep_instr for one cycle; wake sources are raw async levels
`timescale 1ns/1ps

// What this block does
// - sleep only with enable set and instruction
// - mode select chooses idle, noise, power-down, power-save, standby, extended standby
// - four halt cycles after start-up time
// - register file and memory untouched
// - reset during sleep restarts at vector
// - idle stops only core and flash clocks
// - any enabled interrupt wakes from idle
// - entering idle or noise starts conversion
// - noise mode stops io, core, flash
// - noise mode wake sources limited
// - power-down stops oscillator and all clocks
// - power-down wake sources limited
// - power-down wake waits clock-source start-up
// - power-save, extended standby: async domain only with timer2 async
// - standby modes keep main oscillator
// - deep modes: line 2 or levels only
// - comparator disable removes idle wake
// - power-save is power-down plus timer2
// - standby wakes in six cycles
// - extended standby wakes in six cycles
module smc_ctrl
  import smc_pkg::*;
#(
  parameter int STARTUP_CYCLES = 6
)
(
  input  wire logic                mclk,
  input  wire logic                rstn,
  input  wire logic                sleep_enable_bit,
  input  wire logic [2:0]          sleep_mode_select,
  input  wire logic                sleep_instr,
  input  wire logic                timer2_async_clock_sel,
  input  wire logic                crystal_selected,
  input  wire logic                comparator_disable,
  input  wire logic                adc_enabled,
  input  wire logic [SMC_CNT_W-1:0] startup_cycles_cfg,
  input  wire logic                ext_reset_req,
  input  wire logic                ext_irq_line_0,
  input  wire logic                ext_irq_line_1,
  input  wire logic                ext_irq_line_2,
  input  wire logic                ext_irq_level_0,
  input  wire logic                ext_irq_level_1,
  input  wire logic                adc_done_irq,
  input  wire logic                two_wire_port_match_irq,
  input  wire logic                timer2_irq,
  input  wire logic                self_program_store_irq,
  input  wire logic                other_io_irq,
  input  wire logic                comparator_irq,
  output logic                     core_clock_en,
  output logic                     flash_clock_en,
  output logic                     io_clock_en,
  output logic                     converter_clock_en,
  output logic                     async_clock_en,
  output logic                     main_osc_en,
  output logic                     timer_osc_en,
  output logic                     adc_start,
  output logic                     core_resume,
  output logic                     core_reset_vector,
  output logic                     sleeping
);

  if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << SMC_CNT_W))
  begin : g_startup_range
    $error("STARTUP_CYCLES out of range");
  end

  // ----------------------------------------
  // wake event synchronisation
  // ----------------------------------------
  smc_wake_if wk ();

  // raw events are asynchronous: in deep modes the clock domains are stopped
  assign wk.evt_raw = {comparator_irq, other_io_irq, self_program_store_irq,
                       timer2_irq, two_wire_port_match_irq, adc_done_irq};
  assign wk.ext_raw = {ext_irq_line_2, ext_irq_line_1, ext_irq_line_0};

  smc_sync u_sync (
    .mclk (mclk),
    .rstn (rstn),
    .wk   (wk)
  );

  logic rst_meta_q;
  logic rst_sync_q;
  logic lvl_meta_q;
  logic lvl_sync_q;
  logic lvl1_meta_q;
  logic lvl1_sync_q;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rst_meta_q  <= 1'b0;
      rst_sync_q  <= 1'b0;
      lvl_meta_q  <= 1'b0;
      lvl_sync_q  <= 1'b0;
      lvl1_meta_q <= 1'b0;
      lvl1_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q  <= ext_reset_req;
      rst_sync_q  <= rst_meta_q;
      lvl_meta_q  <= ext_irq_level_0;
      lvl_sync_q  <= lvl_meta_q;
      lvl1_meta_q <= ext_irq_level_1;
      lvl1_sync_q <= lvl1_meta_q;
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  logic [2:0] mode_q;
  logic [2:0] mode_d;
  smc_state_t state_q;
  smc_state_t state_d;

  wire m_idle  = (mode_q == SMC_MODE_IDLE);
  wire m_noise = (mode_q == SMC_MODE_NOISE);
  wire m_pdown = (mode_q == SMC_MODE_PDOWN);
  wire m_psave = (mode_q == SMC_MODE_PSAVE);
  wire m_stby  = (mode_q == SMC_MODE_STBY);
  wire m_xstby = (mode_q == SMC_MODE_XSTBY);

  // standby codes need a crystal; reserved codes are refused
  wire sel_ok = (sleep_mode_select == SMC_MODE_IDLE)  ||
                (sleep_mode_select == SMC_MODE_NOISE) ||
                (sleep_mode_select == SMC_MODE_PDOWN) ||
                (sleep_mode_select == SMC_MODE_PSAVE) ||
                (crystal_selected && sleep_mode_select[2] &&
                 sleep_mode_select[1]);

  wire enter = sleep_instr && sleep_enable_bit && sel_ok;

  // ----------------------------------------
  // wake qualification
  // ----------------------------------------
  wire [SMC_WK_W-1:0] ev = wk.evt_sync;
  wire [2:0]          ex = wk.ext_sync;

  // deep modes accept only line 2 or the level-sensitive lines 0/1
  wire ext_deep = ex[2] || (ex[0] && lvl_sync_q) || (ex[1] && lvl1_sync_q);
  wire t2_async = timer2_async_clock_sel;

  wire wake_idle  = (|ex) || ev[SMC_WK_ADC] || ev[SMC_WK_MATCH] || ev[SMC_WK_T2] ||
                    ev[SMC_WK_STORE] || ev[SMC_WK_OTHER] ||
                    (ev[SMC_WK_COMP] && !comparator_disable);
  wire wake_noise = ext_deep || ev[SMC_WK_ADC] || ev[SMC_WK_MATCH] ||
                    ev[SMC_WK_T2] || ev[SMC_WK_STORE];
  wire wake_pdown = ext_deep || ev[SMC_WK_MATCH];
  wire wake_psave = wake_pdown || (ev[SMC_WK_T2] && t2_async);

  wire wake = m_idle  ? wake_idle  :
              m_noise ? wake_noise :
              (m_psave || m_xstby) ? wake_psave : wake_pdown;

  // ----------------------------------------
  // wake delay selection
  // ----------------------------------------
  logic [SMC_CNT_W-1:0] cnt_q;
  logic [SMC_CNT_W-1:0] cnt_d;

  // oscillator stopped: restart time set by clock-source config
  wire osc_stopped = m_pdown || m_psave;
  wire [SMC_CNT_W-1:0] settle_len =
    osc_stopped ? ((startup_cycles_cfg != '0) ? startup_cycles_cfg
                                              : SMC_CNT_W'(STARTUP_CYCLES))
    : (m_stby || m_xstby) ? SMC_CNT_W'(SMC_STBY_CYCLES)
    : SMC_CNT_W'(1);
  wire [SMC_CNT_W-1:0] halt_len = SMC_CNT_W'(SMC_HALT_CYCLES);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    mode_d  = mode_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      SMC_RUN:
      begin
        if (enter)
        begin
          state_d = SMC_SLEEP;
          mode_d  = sleep_mode_select;
        end
      end
      SMC_SLEEP:
      begin
        if (wake)
        begin
          state_d = SMC_SETTLE;
          cnt_d   = settle_len - SMC_CNT_W'(1);
        end
      end
      SMC_SETTLE:
      begin
        if (cnt_q == '0)
        begin
          state_d = SMC_HALT;
          cnt_d   = halt_len - SMC_CNT_W'(1);
        end
        else
          cnt_d = cnt_q - SMC_CNT_W'(1);
      end
      SMC_HALT:
      begin
        if (cnt_q == '0)
          state_d = SMC_RUN;
        else
          cnt_d = cnt_q - SMC_CNT_W'(1);
      end
      default:
        state_d = SMC_RUN;
    endcase
    // reset while asleep abandons the sequence and restarts at the vector
    if (rst_sync_q && state_q != SMC_RUN)
      state_d = SMC_RUN;
  end

  logic resume_q;
  logic vec_q;
  logic adc_q;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state_q  <= SMC_RUN;
      mode_q   <= SMC_MODE_IDLE;
      cnt_q    <= '0;
      resume_q <= 1'b0;
      vec_q    <= 1'b0;
      adc_q    <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      mode_q   <= mode_d;
      cnt_q    <= cnt_d;
      resume_q <= (state_q == SMC_HALT) && (cnt_q == '0) && !rst_sync_q;
      vec_q    <= rst_sync_q && (state_q != SMC_RUN);
      adc_q    <= enter && adc_enabled && (sleep_mode_select == SMC_MODE_IDLE ||
                                           sleep_mode_select == SMC_MODE_NOISE);
    end
  end

  // ----------------------------------------
  // clock gating outputs
  // ----------------------------------------
  // gating only, never reset: register file and memory contents survive
  wire asleep = (state_q == SMC_SLEEP) || (state_q == SMC_SETTLE);
  wire halted = asleep || (state_q == SMC_HALT);

  assign core_clock_en      = !halted;
  assign flash_clock_en     = !halted;
  assign io_clock_en        = !asleep || m_idle;
  assign converter_clock_en = !asleep || m_idle || m_noise;
  assign async_clock_en     = !asleep || m_idle || m_noise ||
                              ((m_psave || m_xstby) && t2_async);
  assign main_osc_en        = !asleep || m_idle || m_noise ||
                              m_stby || m_xstby || (state_q == SMC_SETTLE);
  assign timer_osc_en       = t2_async && (!asleep || m_idle || m_noise ||
                              m_psave || m_xstby);
  assign adc_start          = adc_q;
  assign core_resume        = resume_q;
  assign core_reset_vector  = vec_q;
  assign sleeping           = halted;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  no_enable_sleep_a : assert property (@(posedge mclk) disable iff (!rstn)
    (state_q == SMC_RUN && sleep_instr && !sleep_enable_bit) |=> core_clock_en)
    else $error("sleep taken with enable clear");

  enter_sleep_a : assert property (@(posedge mclk) disable iff (!rstn)
    (state_q == SMC_RUN && enter && !rst_sync_q) |=> !core_clock_en)
    else $error("sleep not entered");

  idle_clocks_a : assert property (@(posedge mclk) disable iff (!rstn)
    (state_q == SMC_SLEEP && m_idle) |-> (io_clock_en && converter_clock_en && !flash_clock_en))
    else $error("idle gating wrong");

  noise_clocks_a : assert property (@(posedge mclk) disable iff (!rstn)
    (state_q == SMC_SLEEP && m_noise) |-> (!io_clock_en && converter_clock_en))
    else $error("noise gating wrong");

  pdown_clocks_a : assert property (@(posedge mclk) disable iff (!rstn)
    (state_q == SMC_SLEEP && m_pdown) |-> !(main_osc_en || async_clock_en || io_clock_en))
    else $error("power-down gating wrong");

  halt_four_a : assert property (@(posedge mclk) disable iff (!rstn || rst_sync_q)
    $rose(state_q == SMC_HALT) && !rst_sync_q |-> (!core_clock_en)[*4] ##1 core_clock_en)
    else $error("halt not four cycles");

  settle_osc_a : assert property (@(posedge mclk) disable iff (!rstn)
    (state_q == SMC_SETTLE) |-> (main_osc_en && !core_clock_en && !flash_clock_en))
    else $error("oscillator off while settling");

  stby_six_a : assert property (@(posedge mclk) disable iff (!rstn)
    (state_q == SMC_SLEEP && m_stby && wake && !rst_sync_q) |=>
      (state_q == SMC_SETTLE)[*6] ##1 (state_q == SMC_HALT))
    else $error("standby wake not six cycles");

  reset_vec_a : assert property (@(posedge mclk) disable iff (!rstn)
    (rst_sync_q && state_q == SMC_SLEEP) |=> (core_reset_vector && !core_resume))
    else $error("reset wake missed vector");

  pdown_wake_a : assert property (@(posedge mclk) disable iff (!rstn)
    (state_q == SMC_SLEEP && m_pdown && !ext_deep && !ev[SMC_WK_MATCH] && !rst_sync_q)
      |=> state_q == SMC_SLEEP)
    else $error("illegal power-down wake");

  adc_start_a : assert property (@(posedge mclk) disable iff (!rstn)
    adc_start |-> $past(enter) && $past(adc_enabled) && !$past(sleep_mode_select[1])
      && !$past(sleep_mode_select[2]))
    else $error("conversion start unexpected");

endmodule : smc_ctrl

// ===== smc_core_model.sv
// smc_core_model: core and wake sources facing smc_ctrl
// assumes: tasks are entered just after a rising edge of mclk
`timescale 1ns/1ps
module smc_core_model
(
  input  wire logic       mclk,
  input  wire logic       core_resume,
  input  wire logic       core_reset_vector,
  output logic            sleep_instr,
  output logic [9:0]      wake_vec
);
  initial
  begin
    sleep_instr = 1'b0;
    wake_vec    = 10'h000;
  end

  // ----
  // sleep instruction
  // ----
  task automatic do_sleep;
    sleep_instr = 1'b1;
    @(posedge mclk);
    #1;
    sleep_instr = 1'b0;
  endtask : do_sleep

  // ----
  // wake levels
  // ----
  // held until answered or lim cycles pass so a level wake is not dropped early
  task automatic raise_wake(input logic [9:0] v, input int lim, output int lat);
    lat      = 0;
    wake_vec = v;
    while (lat < lim && core_resume !== 1'b1 && core_reset_vector !== 1'b1)
    begin
      @(posedge mclk);
      #1;
      lat++;
    end
    wake_vec = 10'h000;
  endtask : raise_wake
endmodule : smc_core_model

// ===== smc_ctrl_tb.sv
// smc_ctrl_tb: self-checking bench for smc_ctrl
// assumes: smc_core_model drives the core and wake side
`timescale 1ns/1ps
module smc_ctrl_tb;
  import smc_pkg::*;

  // wake_vec: 9 cmp,8 other,7 store,6 t2,5 match,4 adc,3..1 lines 2..0,0 reset
  typedef struct packed {
    logic [2:0]  mode;
    logic        xtal;
    logic        t2;
    logic        adc;
    logic        cdis;
    logic [1:0]  lvl;
    logic [15:0] cfg;
    logic [9:0]  bad;
    logic [9:0]  good;
    logic [6:0]  gates;
    logic [7:0]  n;
  } smc_row_t;

  logic        mclk;
  logic        rstn;
  logic        sleep_en;
  smc_row_t    cur;
  logic        sleep_instr;
  logic [9:0]  wk;
  wire  [6:0]  gates;
  logic        resume;
  logic        rvec;
  logic        adc_start;
  logic        sleeping;
  int          fails;
  int          checks;
  int          lat;
  smc_row_t    rows [10] = '{
    '{SMC_MODE_IDLE, 0, 0, 1, 1, 2'h0, 16'h0, 10'h200, 10'h100, 7'h1e, 8'h1},
    '{SMC_MODE_IDLE, 0, 1, 0, 0, 2'h0, 16'h0, 10'h000, 10'h200, 7'h1f, 8'h1},
    '{SMC_MODE_NOISE, 0, 0, 1, 0, 2'h0, 16'h0, 10'h100, 10'h010, 7'h0e, 8'h1},
    '{SMC_MODE_NOISE, 0, 1, 0, 0, 2'h0, 16'h0, 10'h002, 10'h080, 7'h0f, 8'h1},
    '{SMC_MODE_PDOWN, 0, 0, 1, 0, 2'h2, 16'h0, 10'h0d0, 10'h004, 7'h00, 8'h2},
    '{SMC_MODE_PDOWN, 0, 0, 0, 0, 2'h0, 16'h5, 10'h002, 10'h020, 7'h00, 8'h5},
    '{SMC_MODE_PSAVE, 0, 1, 0, 0, 2'h0, 16'h0, 10'h010, 10'h040, 7'h05, 8'h2},
    '{SMC_MODE_PSAVE, 0, 0, 0, 0, 2'h0, 16'h0, 10'h040, 10'h008, 7'h00, 8'h2},
    '{SMC_MODE_STBY, 1, 0, 0, 0, 2'h1, 16'h0, 10'h100, 10'h002, 7'h02, 8'h6},
    '{SMC_MODE_XSTBY, 1, 1, 0, 0, 2'h0, 16'h0, 10'h080, 10'h040, 7'h07, 8'h6}};

  smc_ctrl #(.STARTUP_CYCLES(2)) smc_ctrl_inst (
    .mclk(mclk), .rstn(rstn), .sleep_enable_bit(sleep_en), .sleep_mode_select(cur.mode),
    .sleep_instr(sleep_instr), .timer2_async_clock_sel(cur.t2),
    .crystal_selected(cur.xtal), .comparator_disable(cur.cdis), .adc_enabled(cur.adc),
    .startup_cycles_cfg(cur.cfg), .ext_reset_req(wk[0]), .ext_irq_line_0(wk[1]),
    .ext_irq_line_1(wk[2]), .ext_irq_line_2(wk[3]), .ext_irq_level_0(cur.lvl[0]),
    .ext_irq_level_1(cur.lvl[1]), .adc_done_irq(wk[4]), .two_wire_port_match_irq(wk[5]),
    .timer2_irq(wk[6]), .self_program_store_irq(wk[7]), .other_io_irq(wk[8]),
    .comparator_irq(wk[9]), .core_clock_en(gates[6]), .flash_clock_en(gates[5]),
    .io_clock_en(gates[4]), .converter_clock_en(gates[3]), .async_clock_en(gates[2]),
    .main_osc_en(gates[1]), .timer_osc_en(gates[0]), .adc_start(adc_start),
    .core_resume(resume), .core_reset_vector(rvec), .sleeping(sleeping));

  smc_core_model smc_core_model_inst (
    .mclk(mclk), .core_resume(resume), .core_reset_vector(rvec),
    .sleep_instr(sleep_instr), .wake_vec(wk));

  // ----
  // helpers
  // ----
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic step;
    @(posedge mclk);
    #1;
  endtask : step

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // runs take about 330 cycles; twenty thousand cycles means a hang
  initial
  begin
    #(20000 * 5);
    fails++;
    results();
  end

  // ----
  // sequence
  // ----
  initial
  begin
    fails  = 0;
    checks = 0;
    rstn   = 1'b0;
    sleep_en = 1'b0;
    cur    = rows[1];
    repeat (20) @(posedge mclk);
    #1;
    rstn = 1'b1;
    check("reset gates", gates, 7'h7f);
    check("reset pulses", {resume, rvec, adc_start, sleeping}, 4'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      step();
      cur      = rows[i];
      sleep_en = 1'b1;
      step();
      smc_core_model_inst.do_sleep();
      check("adc_start", adc_start, cur.adc & (cur.mode < 3'h2));
      check("sleep gates", gates, cur.gates);
      check("sleeping", sleeping, 1'b1);
      if (cur.bad != 10'h000)
      begin
        smc_core_model_inst.raise_wake(cur.bad, 16, lat);
        check("ignored wake", 16'(lat), 16'd16);
        step();
      end
      smc_core_model_inst.raise_wake(cur.good, 40, lat);
      check("wake latency", 16'(lat), 16'(7 + cur.n));
      check("resume", {resume, rvec}, 2'h2);
      check("run gates", gates, {6'h3f, cur.t2});
      $display("row %0d done", i);
    end
    // sleep with enable clear, then reserved and uncrystalled codes
    for (int k = 0; k < 3; k++)
    begin
      step();
      cur      = rows[4];
      sleep_en = (k != 0);
      cur.mode = (k == 0) ? SMC_MODE_PDOWN : (k == 1) ? 3'h4 : SMC_MODE_STBY;
      step();
      smc_core_model_inst.do_sleep();
      step();
      check("refused sleep", {sleeping, gates}, 8'h7e);
    end
    $display("refused sleep test done");
    step();
    cur      = rows[4];
    sleep_en = 1'b1;
    step();
    smc_core_model_inst.do_sleep();
    smc_core_model_inst.raise_wake(10'h001, 20, lat);
    check("reset wake latency", 16'(lat), 16'd3);
    check("reset wake pulses", {resume, rvec}, 2'h1);
    $display("reset wake test done");
    // block reset pulled while asleep must give every clock back at once
    step();
    cur      = rows[9];
    sleep_en = 1'b1;
    step();
    smc_core_model_inst.do_sleep();
    check("mid sleep", sleeping, 1'b1);
    rstn = 1'b0;
    repeat (2) step();
    rstn = 1'b1;
    check("mid reset", {sleeping, gates, resume, rvec}, 10'h1fc);
    step();
    check("mid reset run", {sleeping, gates, adc_start}, 9'h0fe);
    $display("mid-run reset test done");
    step();
    results();
  end
endmodule : smc_ctrl_tb
